// *** verilog/csr_core.sv ***
// core special function registers with flag logic
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module csr_core #(
    parameter bit SMALL_MEM = 1'b0
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // register bus
    input wire logic [csr_pkg::ADDR_W-1:0] addr_i,
    input wire logic [csr_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [csr_pkg::DATA_W-1:0] rdata_o,
    // alu
    input wire logic alu_go_i,
    input wire csr_pkg::csr_op_type alu_op_i,
    input wire logic [csr_pkg::DATA_W-1:0] alu_a_i,
    input wire logic [csr_pkg::DATA_W-1:0] alu_b_i,
    output logic [csr_pkg::DATA_W-1:0] acc_o,
    // program counter
    input wire logic [csr_pkg::PC_W-1:0] pc_i,
    output logic pc_load_o,
    output logic [csr_pkg::PC_W-1:0] pc_target_o,
    output logic dummy_o,
    // table read
    input wire logic tbl_rd_i,
    input wire logic [csr_pkg::PW_W-1:0] pm_data_i,
    output logic [csr_pkg::PC_W-1:0] pm_addr_o,
    output logic [csr_pkg::DATA_W-1:0] tbl_low_o,
    output logic tbl_low_vld_o,
    // system events
    input wire logic halt_i,
    input wire logic watchdog_clear_instruction_i,
    input wire logic wdt_timeout_i,
    output logic [csr_pkg::DATA_W-1:0] flags_o,
    output logic irq_o
);
    import csr_pkg::*;

    // ****************************************
    // state
    // ****************************************
    logic [7:0] ptr_a_ff;
    logic [7:0] ptr_b_ff;
    logic [7:0] acc_ff;
    logic [7:0] tptr_lo_ff;
    logic [7:0] tptr_hi_ff;
    logic [7:0] tres_hi_ff;
    logic [7:0] tbl_low_ff;
    logic tbl_low_vld_ff;
    logic c_ff;
    logic ac_ff;
    logic z_ff;
    logic ovf_ff;
    logic to_ff;
    logic pwrdn_ff;
    logic [EVT_W-1:0] evt_ff;
    logic [EVT_W-1:0] mask_ff;
    logic [7:0] rd_q_ff;
    logic ram_sel_ff;
    logic pc_load_ff;
    logic [PC_W-1:0] pc_target_ff;
    logic dummy_ff;

    // ****************************************
    // address decode
    // ****************************************
    wire [7:0] ptr_a_adr;
    wire [7:0] ptr_b_adr;
    wire [7:0] ptr_a_rd;
    wire [7:0] ptr_b_rd;
    wire is_ind;
    wire [7:0] eff;
    wire eff_port;
    wire wr_en;
    wire in_ram;

    // small variant ignores pointer msb and reads it as one
    assign ptr_a_adr = SMALL_MEM ? {1'b0, ptr_a_ff[6:0]} : ptr_a_ff;
    assign ptr_b_adr = SMALL_MEM ? {1'b0, ptr_b_ff[6:0]} : ptr_b_ff;
    assign ptr_a_rd = SMALL_MEM ? (ptr_a_ff | 8'h80) : ptr_a_ff;
    assign ptr_b_rd = SMALL_MEM ? (ptr_b_ff | 8'h80) : ptr_b_ff;

    // port access redirects to the pointer's location
    assign is_ind = (addr_i == OFS_PORT_A) || (addr_i == OFS_PORT_B);
    assign eff = (addr_i == OFS_PORT_A) ? ptr_a_adr :
                 (addr_i == OFS_PORT_B) ? ptr_b_adr : addr_i;
    // a port reached through a pointer is a dead location
    assign eff_port = (eff == OFS_PORT_A) || (eff == OFS_PORT_B);
    assign wr_en = wr_i && !eff_port;
    assign in_ram = (eff >= RAM_BASE);

    // per register write hits
    wire wr_ptr_a = wr_en && (eff == OFS_PTR_A);
    wire wr_ptr_b = wr_en && (eff == OFS_PTR_B);
    wire wr_acc = wr_en && (eff == OFS_ACC);
    wire wr_pc_low = wr_en && (eff == OFS_PC_LOW);
    wire wr_tptr_lo = wr_en && (eff == OFS_TPTR_LO);
    wire wr_tres_hi = wr_en && (eff == OFS_TRES_HI);
    wire wr_tptr_hi = wr_en && (eff == OFS_TPTR_HI);
    wire wr_flags = wr_en && (eff == OFS_FLAGS);
    wire wr_evt = wr_en && (eff == OFS_EVT);
    wire wr_mask = wr_en && (eff == OFS_MASK);
    wire ram_we = wr_en && in_ram;
    wire ram_re = rd_i && in_ram && !eff_port;
    wire [7:0] ram_addr = eff - RAM_BASE;
    wire [7:0] ram_q;

    // ****************************************
    // data memory
    // ****************************************
    csr_ram #(
        .DEPTH(RAM_DEPTH),
        .AW(ADDR_W),
        .DW(DATA_W)
    ) u_ram (
        .clk_i(clk_i),
        .we_i(ram_we),
        .re_i(ram_re),
        .addr_i(ram_addr),
        .wdata_i(wdata_i),
        .q_o(ram_q)
    );

    // ****************************************
    // alu flag computation
    // ****************************************
    wire is_sub = (alu_op_i == OP_SUB);
    wire is_arith = (alu_op_i == OP_ADD) || (alu_op_i == OP_ADC) || is_sub;
    wire is_logic = (alu_op_i == OP_AND) || (alu_op_i == OP_OR) ||
                    (alu_op_i == OP_XOR);
    wire is_rot = (alu_op_i == OP_RLC) || (alu_op_i == OP_RRC);
    wire [7:0] b_eff = is_sub ? ~alu_b_i : alu_b_i;
    wire cin = is_sub ? 1'b1 : ((alu_op_i == OP_ADC) ? c_ff : 1'b0);
    wire [4:0] sum_lo = {1'b0, alu_a_i[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
    wire [7:0] sum_7 = {1'b0, alu_a_i[6:0]} + {1'b0, b_eff[6:0]} + {7'h00, cin};
    wire [8:0] sum = {1'b0, alu_a_i} + {1'b0, b_eff} + {8'h00, cin};

    // result selection
    wire [7:0] alu_res =
        is_arith ? sum[7:0] :
        (alu_op_i == OP_AND) ? (alu_a_i & alu_b_i) :
        (alu_op_i == OP_OR) ? (alu_a_i | alu_b_i) :
        (alu_op_i == OP_XOR) ? (alu_a_i ^ alu_b_i) :
        (alu_op_i == OP_RLC) ? {alu_a_i[6:0], c_ff} :
        {c_ff, alu_a_i[7:1]};
    // carry out of add equals no borrow in subtract
    wire res_c = is_rot ? ((alu_op_i == OP_RLC) ? alu_a_i[7] : alu_a_i[0]) :
                 sum[8];
    wire res_ac = sum_lo[4];
    wire res_ovf = sum_7[7] ^ sum[8];
    wire res_z = (alu_res == 8'h00);

    // ****************************************
    // next flag values
    // ****************************************
    wire alu_c = alu_go_i && (is_arith || is_rot);
    wire alu_az = alu_go_i && (is_arith || is_logic);
    wire alu_ar = alu_go_i && is_arith;
    // alu update wins over a same cycle data write
    wire nxt_c = alu_c ? res_c : (wr_flags ? wdata_i[FLG_C] : c_ff);
    wire nxt_ac = alu_ar ? res_ac : (wr_flags ? wdata_i[FLG_AC] : ac_ff);
    wire nxt_z = alu_az ? res_z : (wr_flags ? wdata_i[FLG_Z] : z_ff);
    wire nxt_ovf = alu_ar ? res_ovf : (wr_flags ? wdata_i[FLG_OVF] : ovf_ff);
    // system flags ignore data writes, time-out set wins
    wire nxt_to = wdt_timeout_i ? 1'b1 : ((halt_i || watchdog_clear_instruction_i) ? 1'b0 : to_ff);
    wire nxt_pwrdn = halt_i ? 1'b1 : (watchdog_clear_instruction_i ? 1'b0 : pwrdn_ff);

    // ****************************************
    // read selection
    // ****************************************
    wire [7:0] flags_rd = {2'b00, to_ff, pwrdn_ff, ovf_ff, z_ff, ac_ff, c_ff};
    wire [7:0] sfr_rd =
        eff_port ? 8'h00 :
        (eff == OFS_PTR_A) ? ptr_a_rd :
        (eff == OFS_PTR_B) ? ptr_b_rd :
        (eff == OFS_ACC) ? acc_ff :
        (eff == OFS_PC_LOW) ? pc_i[7:0] :
        (eff == OFS_TPTR_LO) ? tptr_lo_ff :
        (eff == OFS_TRES_HI) ? tres_hi_ff :
        (eff == OFS_TPTR_HI) ? tptr_hi_ff :
        (eff == OFS_FLAGS) ? flags_rd :
        (eff == OFS_EVT) ? {5'h00, evt_ff} :
        (eff == OFS_MASK) ? {5'h00, mask_ff} :
        8'h00;

    // ****************************************
    // events and interrupt
    // ****************************************
    wire [EVT_W-1:0] evt_set = {wr_pc_low, halt_i, wdt_timeout_i};
    wire [EVT_W-1:0] evt_clr = wr_evt ? wdata_i[EVT_W-1:0] : 3'h0;
    // set wins over a write-one clear
    wire [EVT_W-1:0] nxt_evt = (evt_ff & ~evt_clr) | evt_set;

    // ****************************************
    // pointers, accumulator, table registers
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ptr_a_ff <= RST_BYTE;
            ptr_b_ff <= RST_BYTE;
            tptr_lo_ff <= RST_BYTE;
            tptr_hi_ff <= RST_BYTE;
        end else begin
            if (wr_ptr_a) begin
                ptr_a_ff <= wdata_i;
            end
            if (wr_ptr_b) begin
                ptr_b_ff <= wdata_i;
            end
            if (wr_tptr_lo) begin
                tptr_lo_ff <= wdata_i;
            end
            if (wr_tptr_hi) begin
                tptr_hi_ff <= wdata_i;
            end
        end
    end

    // accumulator takes alu results, else data writes
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            acc_ff <= RST_BYTE;
        end else if (alu_go_i) begin
            acc_ff <= alu_res;
        end else if (wr_acc) begin
            acc_ff <= wdata_i;
        end
    end

    // table read captures both bytes of the word
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            tres_hi_ff <= RST_BYTE;
            tbl_low_ff <= RST_BYTE;
            tbl_low_vld_ff <= 1'b0;
        end else begin
            tbl_low_vld_ff <= tbl_rd_i;
            if (tbl_rd_i) begin
                tres_hi_ff <= pm_data_i[15:8];
                tbl_low_ff <= pm_data_i[7:0];
            end else if (wr_tres_hi) begin
                tres_hi_ff <= wdata_i;
            end
        end
    end

    // ****************************************
    // flags register
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            c_ff <= 1'b0;
            ac_ff <= 1'b0;
            z_ff <= 1'b0;
            ovf_ff <= 1'b0;
            to_ff <= 1'b0;
            pwrdn_ff <= 1'b0;
        end else begin
            c_ff <= nxt_c;
            ac_ff <= nxt_ac;
            z_ff <= nxt_z;
            ovf_ff <= nxt_ovf;
            to_ff <= nxt_to;
            pwrdn_ff <= nxt_pwrdn;
        end
    end

    // ****************************************
    // program counter low write
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pc_load_ff <= 1'b0;
            pc_target_ff <= '0;
            dummy_ff <= 1'b0;
        end else begin
            pc_load_ff <= wr_pc_low;
            dummy_ff <= pc_load_ff;
            if (wr_pc_low) begin
                pc_target_ff <= {pc_i[PC_W-1:8], wdata_i};
            end
        end
    end

    // ****************************************
    // events, mask, read data
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            evt_ff <= RST_EVT;
            mask_ff <= RST_EVT;
            rd_q_ff <= RST_BYTE;
            ram_sel_ff <= 1'b0;
        end else begin
            evt_ff <= nxt_evt;
            if (wr_mask) begin
                mask_ff <= wdata_i[EVT_W-1:0];
            end
            rd_q_ff <= rd_i ? sfr_rd : RST_BYTE;
            ram_sel_ff <= ram_re;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign rdata_o = ram_sel_ff ? ram_q : rd_q_ff;
    assign acc_o = acc_ff;
    assign pc_load_o = pc_load_ff;
    assign pc_target_o = pc_target_ff;
    assign dummy_o = dummy_ff;
    assign pm_addr_o = {tptr_hi_ff[PC_W-9:0], tptr_lo_ff};
    assign tbl_low_o = tbl_low_ff;
    assign tbl_low_vld_o = tbl_low_vld_ff;
    // flags leave here and through register reads; nothing pushes them on call or interrupt
    assign flags_o = flags_rd;
    assign irq_o = |(evt_ff & mask_ff);

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    sequence s_pc_low_wr;
        wr_i && (addr_i == OFS_PC_LOW);
    endsequence
    sequence s_jump;
        pc_load_o && !dummy_o ##1 dummy_o && !pc_load_o;
    endsequence

    AST_JUMP: assert property (s_pc_low_wr |=> s_jump)
        else $error("pc low byte write not followed by load and one dummy cycle");
    AST_PAGE: assert property (s_pc_low_wr |=>
        pc_target_o == {$past(pc_i[PC_W-1:8]), $past(wdata_i)})
        else $error("pc low byte jump target wrong");
    AST_IND_ZERO: assert property (rd_i && is_ind && eff_port |=> rdata_o == 8'h00)
        else $error("indirect port read through pointer not zero");
    AST_MSB_ONE: assert property (SMALL_MEM && rd_i && (addr_i == OFS_PTR_A)
        |=> rdata_o[PTR_MSB])
        else $error("pointer msb not one on small variant");
    AST_TO_SET: assert property (wdt_timeout_i |=> flags_o[FLG_TO])
        else $error("time-out flag not set");
    AST_PD_HOLD: assert property (!halt_i && !watchdog_clear_instruction_i |=> $stable(flags_o[FLG_PWRDN]))
        else $error("power down flag changed without cause");
    AST_SYS_WR: assert property (wr_i && (addr_i == OFS_FLAGS) && !wdt_timeout_i
        && !halt_i && !watchdog_clear_instruction_i |=> $stable(flags_o[5:4]))
        else $error("data write changed system flags");
    AST_ZERO: assert property (alu_go_i && (is_arith || is_logic)
        |=> flags_o[FLG_Z] == (acc_o == 8'h00))
        else $error("zero flag disagrees with result");
    AST_KEEP_C: assert property (alu_go_i && is_logic && !wr_flags
        |=> $stable(flags_o[FLG_C]))
        else $error("logic op changed carry");
    AST_ACC: assert property (alu_go_i && (alu_op_i == OP_ADD)
        |=> acc_o == 8'($past(alu_a_i) + $past(alu_b_i)))
        else $error("accumulator missed alu result");
    AST_TRES: assert property (tbl_rd_i
        |=> tres_hi_ff == $past(pm_data_i[15:8]) && tbl_low_vld_o)
        else $error("table high byte not captured");
    AST_HI0: assert property ($fell(reset_i) |-> flags_o[7:4] == 4'h0)
        else $error("flag bits 7 to 4 not zero after reset");

endmodule
`default_nettype wire

// *** verilog/csr_pkg.sv ***
// constants and types shared by the core special register block
//
// Summary of operation
// - An access to either indirect port is carried out on the data location its pointer holds.
// - An indirect port reached through a pointer reads zero and ignores writes.
// - On the small memory variant pointer bit 7 plays no part in addressing and reads as one.
// - Register to register moves pass through the accumulator, which also takes every ALU result.
// - Writing the program counter low byte loads that byte and keeps the upper bits.
// - A write to the program counter low byte is followed by one dummy cycle.
// - A table read puts the high byte of the addressed program word in the table result register.
// - Data writes to the flags register change only the arithmetic flags.
// - Carry is set on add carry out or on no borrow in subtract, and rotates through carry move it.
// - Auxiliary carry is set on a low nibble carry in add or no nibble borrow in subtract.
// - Zero is set when an arithmetic or logic result is zero and cleared otherwise.
// - Overflow is set when the carry into bit 7 differs from the carry out of it.
// - Power down is cleared by reset or watchdog clear, set by halt, and changed by nothing else.
// - Time-out is cleared by reset, watchdog clear or halt, set by a watchdog time-out only.
// - Interrupts and calls never save the flags register automatically.
// - Flag bits 7 and 6 read zero, bits 5 and 4 are read-only and zero after reset.
package csr_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int PC_W = 11;
    localparam int PW_W = 16;
    localparam int EVT_W = 3;
    localparam int RAM_DEPTH = 192;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] OFS_PORT_A = 8'h00;
    localparam logic [7:0] OFS_PTR_A = 8'h01;
    localparam logic [7:0] OFS_PORT_B = 8'h02;
    localparam logic [7:0] OFS_PTR_B = 8'h03;
    localparam logic [7:0] OFS_ACC = 8'h05;
    localparam logic [7:0] OFS_PC_LOW = 8'h06;
    localparam logic [7:0] OFS_TPTR_LO = 8'h07;
    localparam logic [7:0] OFS_TRES_HI = 8'h08;
    localparam logic [7:0] OFS_TPTR_HI = 8'h09;
    localparam logic [7:0] OFS_FLAGS = 8'h0a;
    localparam logic [7:0] OFS_EVT = 8'h12;
    localparam logic [7:0] OFS_MASK = 8'h13;
    localparam logic [7:0] RAM_BASE = 8'h40;

    // ****************************************
    // flag fields and reset values
    // ****************************************
    localparam int FLG_C = 0;
    localparam int FLG_AC = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_OVF = 3;
    localparam int FLG_PWRDN = 4;
    localparam int FLG_TO = 5;
    localparam int PTR_MSB = 7;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RST_EVT = 3'h0;

    // ****************************************
    // event bits
    // ****************************************
    localparam int EVT_TO = 0;
    localparam int EVT_HALT = 1;
    localparam int EVT_JUMP = 2;

    // ****************************************
    // alu operations
    // ****************************************
    typedef logic [2:0] csr_op_type;
    localparam csr_op_type OP_ADD = 3'h0;
    localparam csr_op_type OP_ADC = 3'h1;
    localparam csr_op_type OP_SUB = 3'h2;
    localparam csr_op_type OP_AND = 3'h3;
    localparam csr_op_type OP_OR = 3'h4;
    localparam csr_op_type OP_XOR = 3'h5;
    localparam csr_op_type OP_RLC = 3'h6;
    localparam csr_op_type OP_RRC = 3'h7;

endpackage

// *** verilog/csr_ram.sv ***
// general purpose data memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module csr_ram #(
    parameter int DEPTH = 192,
    parameter int AW = 8,
    parameter int DW = 8
) (
    // clock
    input wire logic clk_i,
    // access
    input wire logic we_i,
    input wire logic re_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [DW-1:0] wdata_i,
    output logic [DW-1:0] q_o
);

    logic [DW-1:0] mem [DEPTH];
    logic [DW-1:0] q_ff;

    // one write and one read per cycle, both in the same cycle if both strobes are high
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
        if (re_i) begin
            q_ff <= mem[addr_i];
        end
    end

    assign q_o = q_ff;

endmodule
`default_nettype wire

// *** verif/csr_exec_model.sv ***
// behavioural model of the execution core facing the special registers
`timescale 1ns/1ps
`default_nettype none
module csr_exec_model #(
    parameter logic [10:0] START_PC = 11'h5a3
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // program counter
    input wire logic pc_load_i,
    input wire logic [csr_pkg::PC_W-1:0] pc_target_i,
    output logic [csr_pkg::PC_W-1:0] pc_o,
    // program memory
    input wire logic [csr_pkg::PC_W-1:0] pm_addr_i,
    output logic [csr_pkg::PW_W-1:0] pm_data_o
);
    import csr_pkg::*;
    logic [PC_W-1:0] pc_ff;

    // core follows every jump, otherwise stalls on its current word
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pc_ff <= START_PC;
        end else if (pc_load_i) begin
            pc_ff <= pc_target_i;
        end
    end
    assign pc_o = pc_ff;

    // program word pattern: high byte is address bits 7 to 0 xor c3, low byte is address bits 10 to 3
    assign pm_data_o = {pm_addr_i[7:0] ^ 8'hc3, pm_addr_i[10:3]};
endmodule
`default_nettype wire

// *** verif/csr_core_tb.sv ***
// self-checking bench for the core special register block
`timescale 1ns/1ps
`default_nettype none
module csr_core_tb;
    import csr_pkg::*;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic alu_go_i = 1'b0;
    csr_op_type alu_op_i = OP_ADD;
    logic [7:0] alu_a_i = 8'h00;
    logic [7:0] alu_b_i = 8'h00;
    logic tbl_rd_i = 1'b0;
    logic halt_i = 1'b0;
    logic watchdog_clear_instruction_i = 1'b0;
    logic wdt_timeout_i = 1'b0;
    logic [7:0] rdata_o, acc_o, tbl_low_o, flags_o;
    logic [10:0] pc_i, pc_target_o, pm_addr_o;
    logic [15:0] pm_data_i;
    logic pc_load_o, dummy_o, tbl_low_vld_o, irq_o;
    int miscompares = 0;
    int checked = 0;
    logic [3:0] fl;
    logic [1:0] sy;
    logic [11:0] ex;
    localparam csr_op_type OPS[11] = '{OP_ADD, OP_ADC, OP_ADD, OP_SUB, OP_SUB, OP_SUB,
                                       OP_AND, OP_OR, OP_XOR, OP_RLC, OP_RRC};
    localparam logic [7:0] AS[11] = '{8'hff, 8'h10, 8'h7f, 8'h05, 8'h00, 8'h80,
                                      8'hf0, 8'h00, 8'h5a, 8'h80, 8'h01};
    localparam logic [7:0] BS[11] = '{8'h01, 8'h20, 8'h01, 8'h05, 8'h01, 8'h01,
                                      8'h0f, 8'h00, 8'ha5, 8'h00, 8'h00};

    // small memory variant so the pointer top bit is exercised
    csr_core #(.SMALL_MEM(1'b1)) i_csr_core (.clk_i(clk_i), .reset_i(reset_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .alu_go_i(alu_go_i), .alu_op_i(alu_op_i), .alu_a_i(alu_a_i), .alu_b_i(alu_b_i),
        .acc_o(acc_o), .pc_i(pc_i), .pc_load_o(pc_load_o), .pc_target_o(pc_target_o),
        .dummy_o(dummy_o), .tbl_rd_i(tbl_rd_i), .pm_data_i(pm_data_i),
        .pm_addr_o(pm_addr_o), .tbl_low_o(tbl_low_o), .tbl_low_vld_o(tbl_low_vld_o),
        .halt_i(halt_i), .watchdog_clear_instruction_i(watchdog_clear_instruction_i), .wdt_timeout_i(wdt_timeout_i),
        .flags_o(flags_o), .irq_o(irq_o));
    csr_exec_model i_csr_exec_model (.clk_i(clk_i), .reset_i(reset_i),
        .pc_load_i(pc_load_o), .pc_target_i(pc_target_o), .pc_o(pc_i),
        .pm_addr_i(pm_addr_o), .pm_data_o(pm_data_i));

    // 200 MHz clock
    always #2.5 clk_i = ~clk_i;

    // reference alu: returns {ov, z, ac, c, result}
    function automatic logic [11:0] alu_ref(input csr_op_type op, input logic [7:0] a,
                                            input logic [7:0] b, input logic [3:0] f);
        logic [7:0] bb;
        logic [8:0] s;
        logic [4:0] n;
        logic [7:0] l;
        logic [7:0] r;
        logic [3:0] g;
        bb = (op == OP_SUB) ? ~b : b;
        s = {1'b0, a} + {1'b0, bb} + 9'((op == OP_SUB) | ((op == OP_ADC) & f[0]));
        n = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + 5'((op == OP_SUB) | ((op == OP_ADC) & f[0]));
        l = {1'b0, a[6:0]} + {1'b0, bb[6:0]} + 8'((op == OP_SUB) | ((op == OP_ADC) & f[0]));
        g = f;
        case (op)
            OP_AND: r = a & b;
            OP_OR: r = a | b;
            OP_XOR: r = a ^ b;
            OP_RLC: r = {a[6:0], f[0]};
            OP_RRC: r = {f[0], a[7:1]};
            default: r = s[7:0];
        endcase
        if (op == OP_RLC || op == OP_RRC) begin
            g[0] = (op == OP_RLC) ? a[7] : a[0];
        end else if (op == OP_AND || op == OP_OR || op == OP_XOR) begin
            g[2] = (r == 8'h00);
        end else begin
            g = {l[7] ^ s[8], r == 8'h00, n[4], s[8]};
        end
        return {g, r};
    endfunction

    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic close_out;
        if (miscompares == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // one-cycle write, returns at the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    // one-cycle read, data looked at in the single cycle it stands
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk(11'(rdata_o), 11'(exp));
    endtask

    // system event pulse: {halt, clear watchdog, time-out}
    task automatic evt(input logic [2:0] v, input logic [7:0] exp);
        @(posedge clk_i);
        {halt_i, watchdog_clear_instruction_i, wdt_timeout_i} <= v;
        @(posedge clk_i);
        {halt_i, watchdog_clear_instruction_i, wdt_timeout_i} <= 3'h0;
        #1;
        chk(11'(flags_o), 11'(exp));
    endtask

    task automatic alu(input csr_op_type op, input logic [7:0] a, input logic [7:0] b);
        @(posedge clk_i);
        alu_go_i <= 1'b1;
        alu_op_i <= op;
        alu_a_i <= a;
        alu_b_i <= b;
        @(posedge clk_i);
        alu_go_i <= 1'b0;
        #1;
        ex = alu_ref(op, a, b, fl);
        fl = ex[11:8];
        chk(11'(acc_o), 11'(ex[7:0]));
        chk(11'(flags_o), 11'({2'b00, sy, fl}));
    endtask

    // hang guard
    initial begin
        repeat (5000) @(posedge clk_i);
        miscompares++;
        close_out();
    end

    // main sequence
    initial begin
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        rdc(OFS_FLAGS, 8'h00);
        wr(OFS_FLAGS, 8'hff);
        rdc(OFS_FLAGS, 8'h0f);
        evt(3'b100, 8'h1f);
        evt(3'b001, 8'h3f);
        wr(OFS_FLAGS, 8'h00);
        rdc(OFS_FLAGS, 8'h30);
        evt(3'b100, 8'h10);
        rdc(OFS_EVT, 8'h03);
        chk(11'(irq_o), 11'h0);
        wr(OFS_MASK, 8'h02);
        @(posedge clk_i);
        #1 chk(11'(irq_o), 11'h1);
        wr(OFS_EVT, 8'h02);
        @(posedge clk_i);
        #1 chk(11'(irq_o), 11'h0);
        rdc(OFS_EVT, 8'h01);
        evt(3'b010, 8'h00);
        wr(OFS_EVT, 8'h01);
        rdc(8'h04, 8'h00);
        fl = 4'h0;
        sy = 2'b00;
        for (int i = 0; i < 11; i++) begin
            alu(OPS[i], AS[i], BS[i]);
        end
        rdc(OFS_ACC, ex[7:0]);
        // indirect access through both pointers
        wr(OFS_PTR_A, 8'h45);
        rdc(OFS_PTR_A, 8'hc5);
        wr(OFS_PORT_A, 8'h5a);
        rdc(8'h45, 8'h5a);
        wr(OFS_PTR_B, 8'hc6);
        wr(OFS_PORT_B, 8'h3c);
        rdc(8'h46, 8'h3c);
        rdc(OFS_PORT_B, 8'h3c);
        wr(OFS_PTR_B, 8'h00);
        rdc(OFS_PORT_B, 8'h00);
        wr(OFS_PORT_B, 8'h99);
        rdc(8'h45, 8'h5a);
        rdc(OFS_PTR_A, 8'hc5);
        // jumps keep the page of the running program counter
        wr(OFS_PC_LOW, 8'h12);
        #1 chk(11'(pc_load_o), 11'h1);
        chk(pc_target_o, 11'h512);
        @(posedge clk_i);
        #1 chk(11'({pc_load_o, dummy_o}), 11'h1);
        @(posedge clk_i);
        #1 chk(11'(dummy_o), 11'h0);
        rdc(OFS_EVT, 8'h04);
        wr(OFS_PC_LOW, 8'hff);
        #1 chk(pc_target_o, 11'h5ff);
        wr(OFS_PTR_A, 8'h06);
        wr(OFS_PORT_A, 8'h20);
        #1 chk(11'(pc_load_o), 11'h1);
        chk(pc_target_o, 11'h520);
        // table read
        wr(OFS_TPTR_LO, 8'h34);
        wr(OFS_TPTR_HI, 8'h05);
        #1 chk(pm_addr_o, 11'h534);
        @(posedge clk_i);
        tbl_rd_i <= 1'b1;
        @(posedge clk_i);
        tbl_rd_i <= 1'b0;
        #1 chk(11'({tbl_low_vld_o, tbl_low_o}), 11'h1a6);
        rdc(OFS_TRES_HI, 8'hf7);
        close_out();
    end
endmodule
`default_nettype wire
